// File: djp_pkg.sv
// Package of constants for the dual joystick port
package djp_pkg;
    localparam logic [15:0] STATUS_OFFSET    = 16'h0000;
    localparam logic [7:0]  BASE_HIGH_INDEX  = 8'h60;
    localparam logic [7:0]  BASE_LOW_INDEX   = 8'h61;
    localparam logic [7:0]  ACTIVATE_INDEX   = 8'h30;
    localparam logic [7:0]  POWER_CTRL_INDEX = 8'h22;
    localparam int          POWER_GAME_BIT   = 2;
    localparam logic [7:0]  STATUS_RESET     = 8'h00;
    localparam logic [7:0]  BASE_HIGH_RESET  = 8'h00;
    localparam logic [7:0]  BASE_LOW_RESET   = 8'h00;
    localparam int          STICK1_X_POS     = 0;
    localparam int          STICK1_Y_POS     = 1;
    localparam int          STICK2_X_POS     = 2;
    localparam int          STICK2_Y_POS     = 3;
    localparam int          STICK1_BTN1_POS  = 4;
    localparam int          STICK1_BTN2_POS  = 5;
    localparam int          STICK2_BTN1_POS  = 6;
    localparam int          STICK2_BTN2_POS  = 7;
    localparam int          CLK_FREQ_HZ      = 20_000_000;
    localparam int          MIN_RC_NS        = 20_000;
    localparam int          MIN_RC_CYCLES    =
        (MIN_RC_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;
    localparam int          DISCHARGE_CYCLES = 4;
endpackage

// File: djp_axis_timer.sv
// One axis timing channel: trip detect and RC discharge control
`timescale 1ns/1ns
module djp_axis_timer #(
    parameter int DISCHARGE_LEN = 4
) (
    input  wire logic sys_clk_in,
    input  wire logic rst_in,
    input  wire logic restart_in,
    input  wire logic trip_in,
    output logic      timer_bit_out,
    output logic      discharge_out
);
    initial begin
        if (DISCHARGE_LEN < 1 || DISCHARGE_LEN > 255) begin
            $error("DISCHARGE_LEN out of range");
        end
    end

    logic       timer_q;
    logic       timer_d;
    logic [7:0] dis_cnt_q;
    logic [7:0] dis_cnt_d;
    logic       dis_q;
    logic       dis_d;

    always_comb begin
        timer_d   = timer_q;
        dis_cnt_d = dis_cnt_q;
        dis_d     = 1'b0;
        if (restart_in) begin
            timer_d   = 1'b1; // R13
            dis_cnt_d = 8'(DISCHARGE_LEN);
        end else if (dis_cnt_q != 8'h00) begin
            dis_cnt_d = dis_cnt_q - 8'h01;
        end else if (timer_q && trip_in) begin
            timer_d   = 1'b0; // R3
            dis_cnt_d = 8'(DISCHARGE_LEN);
        end
        if (dis_cnt_d != 8'h00) begin
            dis_d = 1'b1; // R3
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            timer_q   <= 1'b0;
            dis_cnt_q <= 8'h00;
            dis_q     <= 1'b0;
        end else begin
            timer_q   <= timer_d;
            dis_cnt_q <= dis_cnt_d;
            dis_q     <= dis_d;
        end
    end

    assign timer_bit_out = timer_q;
    assign discharge_out = dis_q;

    trip_clears_a: assert property (@(posedge sys_clk_in) // R3
        disable iff (rst_in)
        timer_q && trip_in && !restart_in && dis_cnt_q == 8'h00
        |=> !timer_q && dis_q)
        else $error("trip did not clear timer and discharge");
    restart_sets_a: assert property (@(posedge sys_clk_in) // R13
        disable iff (rst_in)
        restart_in |=> timer_q && dis_q)
        else $error("restart did not set timer bit");
    holds_high_a: assert property (@(posedge sys_clk_in) // R13
        disable iff (rst_in)
        timer_q && !trip_in && !restart_in |=> timer_q)
        else $error("timer bit dropped without trip");
endmodule

// File: djp_port.sv
// Dual joystick port: config bytes, I/O decode and status register
`timescale 1ns/1ns
// Functional notes
// R1 - Two joysticks, each with X and Y timing channels and two buttons.
// R2 - Host writes any byte, then polls until axis bits fall to zero.
// R3 - At trip threshold an axis bit clears and its RC pin discharges.
// R4 - Status sits at base plus zero, reads zero after standby reset.
// R5 - Status is eight bits, read only; writes store nothing.
// R6 - Bits: 1X,1Y,2X,2Y, then stick1 buttons, then stick2 buttons.
// R7 - Any port write discharges all RC pins at strobe trailing edge.
// R8 - I/O read or write at the base address is a port access.
// R9 - Base address high byte at index 60h, low byte at 61h.
// R10 - With activate clear the base address is not decoded.
// R11 - Power control bit 2 and activate bit mirror each other.
// R12 - RC networks must have at least a 20 us time constant.
// R13 - After a write each axis bit reads one until its input trips.
module djp_port #(
    parameter int DISCHARGE_LEN = djp_pkg::DISCHARGE_CYCLES
) (
    input  wire logic        sys_clk_in,
    input  wire logic        rst_in,
    input  wire logic [15:0] io_addr_in,
    input  wire logic        io_rd_in,
    input  wire logic        io_wr_in,
    input  wire logic [7:0]  cfg_index_in,
    input  wire logic [7:0]  cfg_wdata_in,
    input  wire logic        cfg_wr_in,
    input  wire logic        cfg_rd_in,
    input  wire logic [3:0]  axis_trip_in,
    input  wire logic [3:0]  button_in,
    output logic [7:0]       io_rdata_out,
    output logic             port_read_strobe_out,
    output logic             port_write_strobe_out,
    output logic [7:0]       cfg_rdata_out,
    output logic [3:0]       axis_discharge_out
);
    initial begin
        if (DISCHARGE_LEN < 1 || DISCHARGE_LEN > 255) begin
            $error("DISCHARGE_LEN out of range");
        end
    end

    logic [7:0] base_hi_q;
    logic [7:0] base_hi_d;
    logic [7:0] base_lo_q;
    logic [7:0] base_lo_d;
    logic       active_q;
    logic       active_d;
    logic [7:0] cfg_rdata_q;
    logic [7:0] cfg_rdata_d;

    // Activate bit and power bit are one flop, so they can never disagree
    always_comb begin
        base_hi_d   = base_hi_q;
        base_lo_d   = base_lo_q;
        active_d    = active_q;
        cfg_rdata_d = cfg_rdata_q;
        if (cfg_wr_in) begin
            unique case (cfg_index_in)
                djp_pkg::BASE_HIGH_INDEX:  base_hi_d = cfg_wdata_in; // R9
                djp_pkg::BASE_LOW_INDEX:   base_lo_d = cfg_wdata_in; // R9
                djp_pkg::ACTIVATE_INDEX:   active_d = cfg_wdata_in[0]; // R11
                djp_pkg::POWER_CTRL_INDEX:
                    active_d = cfg_wdata_in[djp_pkg::POWER_GAME_BIT]; // R11
                default: ;
            endcase
        end
        if (cfg_rd_in) begin
            unique case (cfg_index_in)
                djp_pkg::BASE_HIGH_INDEX:  cfg_rdata_d = base_hi_q;
                djp_pkg::BASE_LOW_INDEX:   cfg_rdata_d = base_lo_q;
                djp_pkg::ACTIVATE_INDEX:   cfg_rdata_d = {7'h00, active_q};
                djp_pkg::POWER_CTRL_INDEX:
                    cfg_rdata_d = {5'h00, active_q, 2'h0}; // R11
                default:                   cfg_rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            base_hi_q   <= djp_pkg::BASE_HIGH_RESET;
            base_lo_q   <= djp_pkg::BASE_LOW_RESET;
            active_q    <= 1'b0;
            cfg_rdata_q <= 8'h00;
        end else begin
            base_hi_q   <= base_hi_d;
            base_lo_q   <= base_lo_d;
            active_q    <= active_d;
            cfg_rdata_q <= cfg_rdata_d;
        end
    end

    // Port access decode and write trailing edge
    logic       hit;
    logic       wr_hit_q;
    logic       wr_hit_d;
    logic       restart;
    logic       rd_stb_q;
    logic       rd_stb_d;
    logic       wr_stb_q;
    logic       wr_stb_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic [3:0] axis_bits;
    logic [3:0] discharge;
    logic [3:0] dis_q;

    assign hit = active_q && (io_addr_in ==
        ({base_hi_q, base_lo_q} + djp_pkg::STATUS_OFFSET)); // R8 R10

    // Restart fires when an accepted write strobe goes inactive
    assign restart = wr_hit_q && !io_wr_in; // R7

    always_comb begin
        wr_hit_d = wr_hit_q;
        if (io_wr_in && hit) begin
            wr_hit_d = 1'b1; // R8
        end else if (!io_wr_in) begin
            wr_hit_d = 1'b0;
        end
        rd_stb_d = io_rd_in && hit; // R8
        wr_stb_d = io_wr_in && hit; // R8
        rdata_d  = rdata_q;
        if (io_rd_in && hit) begin
            rdata_d[djp_pkg::STICK1_X_POS]    = axis_bits[0]; // R6
            rdata_d[djp_pkg::STICK1_Y_POS]    = axis_bits[1]; // R6
            rdata_d[djp_pkg::STICK2_X_POS]    = axis_bits[2]; // R6
            rdata_d[djp_pkg::STICK2_Y_POS]    = axis_bits[3]; // R6
            rdata_d[djp_pkg::STICK1_BTN1_POS] = button_in[0]; // R6
            rdata_d[djp_pkg::STICK1_BTN2_POS] = button_in[1]; // R6
            rdata_d[djp_pkg::STICK2_BTN1_POS] = button_in[2]; // R6
            rdata_d[djp_pkg::STICK2_BTN2_POS] = button_in[3]; // R6
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_hit_q <= 1'b0;
            rd_stb_q <= 1'b0;
            wr_stb_q <= 1'b0;
            rdata_q  <= djp_pkg::STATUS_RESET; // R4
            dis_q    <= 4'h0;
        end else begin
            wr_hit_q <= wr_hit_d;
            rd_stb_q <= rd_stb_d;
            wr_stb_q <= wr_stb_d;
            rdata_q  <= rdata_d;
            dis_q    <= discharge;
        end
    end

    // Four identical channels: stick1 X,Y then stick2 X,Y
    for (genvar i = 0; i < 4; i++) begin : g_axis // R1
        djp_axis_timer #(
            .DISCHARGE_LEN (DISCHARGE_LEN)
        ) u_axis (
            .sys_clk_in    (sys_clk_in),
            .rst_in        (rst_in),
            .restart_in    (restart),
            .trip_in       (axis_trip_in[i]),
            .timer_bit_out (axis_bits[i]),
            .discharge_out (discharge[i])
        );
    end

    assign io_rdata_out          = rdata_q; // R5
    assign port_read_strobe_out  = rd_stb_q;
    assign port_write_strobe_out = wr_stb_q;
    assign cfg_rdata_out         = cfg_rdata_q;
    assign axis_discharge_out    = dis_q;

    inactive_ignored_a: assert property (@(posedge sys_clk_in) // R10
        disable iff (rst_in)
        !active_q |=> !port_read_strobe_out && !port_write_strobe_out)
        else $error("access decoded while inactive");
    trailing_discharge_a: assert property (@(posedge sys_clk_in) // R7
        disable iff (rst_in)
        restart |-> ##2 axis_discharge_out == 4'hf)
        else $error("write trailing edge did not discharge all pins");
    // A one-cycle write strobe legally restarts on the very next edge
    no_early_discharge_a: assert property (@(posedge sys_clk_in) // R7
        disable iff (rst_in)
        restart |-> !io_wr_in && $past(io_wr_in))
        else $error("restart before trailing edge");
    write_restart_a: assert property (@(posedge sys_clk_in) // R7
        disable iff (rst_in)
        io_wr_in && hit ##1 !io_wr_in |-> restart)
        else $error("write trailing edge did not restart timers");
    status_layout_a: assert property (@(posedge sys_clk_in) // R6
        disable iff (rst_in)
        io_rd_in && hit |=> io_rdata_out[7:4] == $past(button_in))
        else $error("button bits misplaced");
    axis_layout_a: assert property (@(posedge sys_clk_in) // R6
        disable iff (rst_in)
        io_rd_in && hit |=> io_rdata_out[3:0] == $past(axis_bits))
        else $error("axis bits misplaced");
    status_readonly_a: assert property (@(posedge sys_clk_in) // R5
        disable iff (rst_in)
        !io_rd_in |=> $stable(io_rdata_out))
        else $error("status changed without a read");
    power_mirror_a: assert property (@(posedge sys_clk_in) // R11
        disable iff (rst_in)
        cfg_wr_in && cfg_index_in == djp_pkg::POWER_CTRL_INDEX
        |=> active_q == $past(cfg_wdata_in[djp_pkg::POWER_GAME_BIT]))
        else $error("power bit did not reach activate");
    power_readback_a: assert property (@(posedge sys_clk_in) // R11
        disable iff (rst_in)
        cfg_rd_in && cfg_index_in == djp_pkg::POWER_CTRL_INDEX
        |=> cfg_rdata_out[djp_pkg::POWER_GAME_BIT] == $past(active_q))
        else $error("power bit does not show activate");
    base_load_a: assert property (@(posedge sys_clk_in) // R9
        disable iff (rst_in)
        cfg_wr_in && cfg_index_in == djp_pkg::BASE_HIGH_INDEX
        |=> base_hi_q == $past(cfg_wdata_in))
        else $error("base high byte not stored");
    base_low_load_a: assert property (@(posedge sys_clk_in) // R9
        disable iff (rst_in)
        cfg_wr_in && cfg_index_in == djp_pkg::BASE_LOW_INDEX
        |=> base_lo_q == $past(cfg_wdata_in))
        else $error("base low byte not stored");
    read_strobe_a: assert property (@(posedge sys_clk_in) // R8
        disable iff (rst_in)
        io_rd_in && hit |=> port_read_strobe_out)
        else $error("port read not decoded");
endmodule

// File: djp_rc_model.sv
// RC timing network model for the four joystick axes
`timescale 1ns/1ns
module djp_rc_model #(
    parameter int RC_CYCLES = 400
) (
    input  wire logic       sys_clk_in,
    input  wire logic       rst_in,
    input  wire logic [3:0] discharge_in,
    output logic [3:0]      trip_out
);
    int level_q [4];

    // Capacitor charge grows from release of discharge; saturates
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        for (int i = 0; i < 4; i++) begin
            if (rst_in || discharge_in[i]) begin
                level_q[i] <= 0;
            end else if (level_q[i] < 4096) begin
                level_q[i] <= level_q[i] + 1;
            end
        end
    end

    // Each axis slower than the last, none under the minimum constant
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            trip_out[i] = level_q[i] >= RC_CYCLES * (i + 2) / 2;
        end
    end
endmodule

// File: dual_joystick_port_tb.sv
// Testbench for the dual joystick port with an RC network model
`timescale 1ns/1ns
module dual_joystick_port_tb;
    localparam int          DLEN = 4;
    localparam logic [15:0] BASE = 16'h1234;
    logic        sys_clk_in, rst_in, io_rd_in, io_wr_in, cfg_wr_in, cfg_rd_in;
    logic        port_read_strobe_out, port_write_strobe_out, st;
    logic [15:0] io_addr_in;
    logic [7:0]  cfg_index_in, cfg_wdata_in, io_rdata_out, cfg_rdata_out, s;
    logic [3:0]  axis_trip_in, button_in, axis_discharge_out, dprev;
    int          error_cnt, n_compared, cyc, t0, k;
    int          t [4];
    int          pulses [4];

    djp_port #(.DISCHARGE_LEN(DLEN)) djp_port_i (.sys_clk_in(sys_clk_in),
        .rst_in(rst_in), .io_addr_in(io_addr_in), .io_rd_in(io_rd_in),
        .io_wr_in(io_wr_in), .cfg_index_in(cfg_index_in),
        .cfg_wdata_in(cfg_wdata_in), .cfg_wr_in(cfg_wr_in),
        .cfg_rd_in(cfg_rd_in), .axis_trip_in(axis_trip_in),
        .button_in(button_in), .io_rdata_out(io_rdata_out),
        .port_read_strobe_out(port_read_strobe_out),
        .port_write_strobe_out(port_write_strobe_out),
        .cfg_rdata_out(cfg_rdata_out), .axis_discharge_out(axis_discharge_out));
    djp_rc_model #(.RC_CYCLES(400)) djp_rc_model_i (.sys_clk_in(sys_clk_in),
        .rst_in(rst_in), .discharge_in(axis_discharge_out),
        .trip_out(axis_trip_in));

    initial begin
        sys_clk_in = 1'b0;
        forever #25 sys_clk_in = ~sys_clk_in;
    end

    // Counts discharge pulses per axis; also cuts a hang short
    always @(posedge sys_clk_in) begin
        cyc <= cyc + 1;
        dprev <= axis_discharge_out;
        for (int i = 0; i < 4; i++) begin
            if (axis_discharge_out[i] === 1'b1 && dprev[i] === 1'b0) begin
                pulses[i] <= pulses[i] + 1;
            end
        end
        if (cyc == 20000) begin
            error_cnt++;
            summarize();
        end
    end

    task automatic check(input string name, input logic [7:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic cfg_wr(input logic [7:0] idx, data);
        @(posedge sys_clk_in);
        cfg_wr_in <= 1'b1;
        cfg_index_in <= idx;
        cfg_wdata_in <= data;
        @(posedge sys_clk_in);
        cfg_wr_in <= 1'b0;
    endtask

    task automatic cfg_chk(input logic [7:0] idx, exp);
        @(posedge sys_clk_in);
        cfg_rd_in <= 1'b1;
        cfg_index_in <= idx;
        @(posedge sys_clk_in);
        cfg_rd_in <= 1'b0;
        #1 check("config byte", cfg_rdata_out, exp);
    endtask

    // Read or write cycle of one clock; strobe sampled once it settles
    task automatic io_cyc(input logic [15:0] a, input logic wr);
        @(posedge sys_clk_in);
        io_addr_in <= a;
        if (wr) io_wr_in <= 1'b1;
        else io_rd_in <= 1'b1;
        @(posedge sys_clk_in);
        io_wr_in <= 1'b0;
        io_rd_in <= 1'b0;
        #1 s = io_rdata_out;
        st = wr ? port_write_strobe_out : port_read_strobe_out;
    endtask

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        {rst_in, io_rd_in, io_wr_in, cfg_wr_in, cfg_rd_in} = 5'h10;
        {io_addr_in, cfg_index_in, cfg_wdata_in, button_in} = '0;
        {cyc, error_cnt, n_compared} = '0;
        repeat (4) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        cfg_chk(8'h60, 8'h00);
        cfg_wr(8'h60, 8'h12);
        cfg_wr(8'h61, 8'h34);
        cfg_chk(8'h60, 8'h12);
        cfg_chk(8'h61, 8'h34);
        cfg_chk(8'h70, 8'h00);
        io_cyc(BASE, 1'b0);
        check("inactive read", {7'h0, st}, 8'h00);
        io_cyc(BASE, 1'b1);
        repeat (10) @(posedge sys_clk_in);
        check("inactive write", 8'(pulses[0]), 8'h00);
        cfg_wr(8'h22, 8'h04);
        cfg_chk(8'h30, 8'h01);
        cfg_wr(8'h30, 8'h00);
        cfg_chk(8'h22, 8'h00);
        cfg_wr(8'h30, 8'h01);
        cfg_chk(8'h22, 8'h04);
        io_cyc(BASE + 16'h0001, 1'b0);
        check("miss read", {7'h0, st}, 8'h00);
        io_cyc(BASE, 1'b0);
        check("hit read", {7'h0, st}, 8'h01);
        check("status reset", s, 8'h00);
        io_cyc(BASE, 1'b1);
        check("hit write", {7'h0, st}, 8'h01);
        t0 = cyc;
        for (k = 0; k < 10 && axis_discharge_out !== 4'hf; k++) begin
            @(posedge sys_clk_in) #1;
        end
        for (k = 0; k < 20 && axis_discharge_out === 4'hf; k++) begin
            @(posedge sys_clk_in) #1;
        end
        check("discharge length", 8'(k), 8'(DLEN));
        io_cyc(BASE, 1'b0);
        check("status after write", s, 8'h0f);
        t = '{default: 0};
        for (k = 0; k < 700 && s[3:0] !== 4'h0; k++) begin
            io_cyc(BASE, 1'b0);
            for (int i = 0; i < 4; i++) begin
                if (s[i] === 1'b0 && t[i] == 0) t[i] = cyc - t0;
            end
        end
        // Last trip pulse reaches the pin one edge after its bit falls
        repeat (2 * DLEN) @(posedge sys_clk_in);
        for (int i = 0; i < 4; i++) begin
            check("fall time", 8'(t[i] >= 200 * (i + 2)
                && t[i] <= 200 * (i + 2) + 40), 8'h01);
            check("trip discharge", 8'(pulses[i]), 8'h02);
        end
        for (k = 0; k < 16; k++) begin
            @(posedge sys_clk_in);
            button_in <= 4'(k);
            io_cyc(BASE, 1'b0);
            check("buttons", s, {4'(k), 4'h0});
        end
        summarize();
    end
endmodule
